// file: logic/ews_csum.sv
// Running integrity checksum over guest state words.
// Assumes words arrive one per cycle from the save area steps.
`timescale 1ns/10ps
module ews_csum (
   input wire logic clk, // Core clock
   input wire logic nrst, // Async reset, active low
   input wire logic clear, // Restart the sum
   input wire logic word_valid, // Word present
   input wire logic [63:0] word, // State word
   output logic [63:0] sum // Current sum
);
   logic [63:0] next_sum;

   always_comb
   begin
      next_sum = sum;
      if (clear)
      begin
         next_sum = ews_pkg::CSUM_RESET;
      end
      else if (word_valid)
      begin
         next_sum = {sum[62:0], sum[63]} ^ word;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         sum <= ews_pkg::CSUM_RESET;
      end
      else
      begin
         sum <= next_sum;
      end
   end
endmodule // ews_csum

// file: logic/ews_pkg.sv
// Shared constants, codes and carriers of the encrypted guest world switch.
// Assumes a single core clock shared by guest and hypervisor facing logic.
package ews_pkg;

   localparam int unsigned CODE_W = 16;
   localparam logic [7:0] COMM_EXC_VECTOR = 8'h1D;
   localparam logic [31:0] COMM_PAGE_MSR = 32'hC0010130;
   localparam logic [63:0] COMM_PAGE_RESET = 64'h0;
   localparam logic [11:0] CB_COMM_PAGE_OFS = 12'h0A0;
   localparam logic [11:0] CB_SAVE_PTR_OFS = 12'h108;
   localparam logic [11:0] CB_LEGACY_SAVE_OFS = 12'h400;
   localparam logic [63:0] SAVE_AREA_OFS = 64'h0;
   localparam logic [63:0] CSUM_RESET = 64'h0;

   localparam logic [CODE_W-1:0] CODE_MC = 16'h0052;
   localparam logic [CODE_W-1:0] CODE_INTR = 16'h0060;
   localparam logic [CODE_W-1:0] CODE_SMI = 16'h0062;
   localparam logic [CODE_W-1:0] CODE_VINTR = 16'h0064;
   localparam logic [CODE_W-1:0] CODE_PAUSE = 16'h0077;
   localparam logic [CODE_W-1:0] CODE_HLT = 16'h0078;
   localparam logic [CODE_W-1:0] CODE_SHUTDOWN = 16'h007F;
   localparam logic [CODE_W-1:0] CODE_FEAT_TRAP = 16'h008F;
   localparam logic [CODE_W-1:0] CODE_CR_TRAP = 16'h0090;
   localparam logic [CODE_W-1:0] CODE_CR_TRAP_LAST = 16'h009F;
   localparam logic [CODE_W-1:0] CODE_NPF = 16'h0400;
   localparam logic [CODE_W-1:0] CODE_GEXIT = 16'h0403;
   localparam logic [CODE_W-1:0] CODE_INVALID = 16'hFFFF;
   localparam logic [CODE_W-1:0] CODE_BUSY = 16'hFFFE;

   localparam int unsigned CLEAN_IGN_LO = 5;
   localparam int unsigned CLEAN_IGN_HI = 10;
   localparam logic [31:0] CLEAN_IGN_MASK = 32'h000007E0;
   localparam int unsigned MC_REDIRECT_BIT = 0;
   localparam int unsigned VIRT_ENABLE_BIT = 12;
   localparam logic [2:0] INJ_TYPE_EXC = 3'h3;
   localparam logic [2:0] INJ_TYPE_SWINT = 3'h4;
   localparam logic [7:0] VEC_BREAK = 8'h03;
   localparam logic [7:0] VEC_OVERFLOW = 8'h04;

   typedef enum logic [3:0] {
      OP_NONE, OP_HOST_MIN_SAVE, OP_CSUM_CHECK, OP_XLOAD_GUEST, OP_LOAD_GPR, OP_LOAD_FP,
      OP_XSAVE_GUEST, OP_SAVE_GPR, OP_SAVE_FP, OP_STORE_CSUM, OP_XLOAD_HOST,
      OP_LOAD_HOST_GPR, OP_RESET_FP
   } ews_op_t;

   typedef enum logic [1:0] {ST_HOST, ST_ENTRY, ST_GUEST, ST_EXIT} ews_state_t;

   typedef struct packed {
      logic valid;
      logic [CODE_W-1:0] code;
      logic intercept;
      logic npf_rsvd;
   } ews_evt_t;

   typedef struct packed {
      logic valid;
      logic enc_mode;
      logic [31:0] clean;
      logic [63:0] save_ptr;
      logic [63:0] comm_page;
      logic inj_valid;
      logic [2:0] inj_type;
      logic [7:0] inj_vec;
   } ews_entry_t;

   typedef struct packed {
      logic valid;
      logic [7:0] vector;
      logic [CODE_W-1:0] error_code;
      logic precise;
      logic contributory;
      logic fault;
   } ews_exc_t;

   typedef struct packed {
      logic valid;
      logic [CODE_W-1:0] code;
      logic [63:0] info1;
      logic adv_ip;
      logic [63:0] comm_page;
   } ews_exit_t;

   typedef struct packed {
      logic valid;
      ews_op_t op;
      logic [63:0] addr;
      logic enc_key;
      logic [63:0] wdata;
   } ews_step_t;

   typedef struct packed {
      logic ack;
      logic fault;
      logic [63:0] data;
   } ews_resp_t;

   typedef struct packed {
      logic valid;
      logic write;
      logic [31:0] addr;
      logic [63:0] wdata;
      logic guest_mode;
   } ews_msr_req_t;

   typedef struct packed {
      logic valid;
      logic [63:0] rdata;
      logic gp_fault;
   } ews_msr_rsp_t;

   typedef struct packed {
      logic valid;
      logic feat;
      logic [3:0] idx;
      logic [63:0] value;
   } ews_crw_t;

endpackage

// file: logic/ews_switch.sv
// World switch sequencer for encrypted-state guests: communication exception,
// guest exit instruction, shared page MSR, entry and automatic exit steps.
// Assumes core-clock inputs from decode, MSR unit and a save-area mover.
`timescale 1ns/10ps

// Functional notes
// - Non-automatic exit in encrypted guest raises the communication exception.
// - Exception is precise, contributory, fault class, vector 29.
// - Exception has no mask; raised unless an interrupt, guest exit opcode or register write is taken in the same cycle.
// - Error code equals the exit code of the causing event.
// - Guest exit instruction gives automatic exit, code 403h, trap semantics.
// - Guest exit instruction always exits in encrypted guest; no intercept.
// - Outside encrypted mode the opcode acts as hypervisor call.
// - Shared page MSR saved at control block 0A0h, restored on entry.
// - Shared page MSR accessible only in guest mode; host access faults.
// - Save state taken from separate page via pointer at 108h.
// - Every guest save area access uses the guest encryption key; host save area steps do not.
// - Entry verifies checksum, extra load, then general and FP loads.
// - Fault or checksum mismatch on entry gives invalid-state exit.
// - Clean bits 10:5 ignored; full reload always in encrypted mode.
// - Entry saves only minimal host state; hypervisor stores the rest.
// - Injecting software interrupt or exception vector 3 or 4 fails entry.
// - Exit saves extra, general, FP, checksum; then restores host state.
// - Host registers loaded or reset at exit; no guest values leak.
// - Control and feature register write traps exit with new value.
// - Guest writes to virtualization enable bit are discarded.
// - Interrupt for system management held pending, forces exit, served later.
// - Machine check via that interrupt sets redirect bit in exit info.
// - Pause, halt and guest exit instruction advance instruction pointer.
// - Core event exits taken only when matching intercept bit is set.
module ews_switch (
   input wire logic clk, // Core clock, 125 MHz
   input wire logic nrst, // Async reset, active low
   input ews_pkg::ews_entry_t entry, // Guest entry request with block fields
   input wire logic [63:0] host_save_pa, // Host save area address
   input ews_pkg::ews_evt_t evt, // Exit event from the core
   input wire logic gexit_insn, // Guest exit opcode retired
   input ews_pkg::ews_crw_t crw, // Control or feature register write
   input wire logic [15:0] cr_trap_en, // Control register write traps
   input wire logic feat_trap_en, // Feature register write trap
   input wire logic virt_enable_now, // Current virtualization enable bit
   input wire logic smi_in, // System management interrupt pulse
   input wire logic smi_mc, // That interrupt carries a machine check
   input wire logic gis_insn, // Global interrupt set executed
   input ews_pkg::ews_msr_req_t msr_req, // MSR access
   input ews_pkg::ews_resp_t step_resp, // Save area step answer
   input wire logic word_valid, // Save area word seen
   input wire logic [63:0] word, // Save area word
   output ews_pkg::ews_exc_t exc, // Exception raise pulse
   output ews_pkg::ews_exit_t exit_rpt, // Exit report pulse
   output ews_pkg::ews_step_t step, // Save area step request pulse
   output ews_pkg::ews_msr_rsp_t msr_rsp, // MSR answer pulse
   output ews_pkg::ews_crw_t commit, // Register write commit pulse
   output logic hcall, // Hypervisor call behaviour pulse
   output logic smi_service, // Release held interrupt pulse
   output logic smi_held, // Interrupt held pending
   output logic guest_running, // Guest executing
   output logic full_reload, // Clean bits overridden
   output logic [31:0] clean_eff // Effective clean bits
);
   typedef struct packed {
      ews_pkg::ews_state_t st;
      ews_pkg::ews_op_t op;
      logic busy;
      logic enc;
      logic [15:0] code;
      logic [63:0] info1;
      logic adv;
      logic [63:0] comm_page;
      logic [63:0] save_ptr;
      logic held;
      logic held_mc;
      logic running;
      logic reload;
      logic [31:0] clean;
      ews_pkg::ews_exc_t exc;
      ews_pkg::ews_exit_t exit_rpt;
      ews_pkg::ews_step_t step;
      ews_pkg::ews_msr_rsp_t msr_rsp;
      ews_pkg::ews_crw_t commit;
      logic hcall;
      logic smi_service;
   } ews_regs_t;

   ews_regs_t s;
   ews_regs_t next_s;
   logic csum_clear;
   logic [63:0] csum;
   logic do_exit;
   logic [15:0] ex_code;
   logic [63:0] ex_info;
   logic ex_adv;
   logic bad_inj;
   logic [63:0] wr_val;
   logic trap_hit;

   ews_csum u_csum (
      .clk(clk),
      .nrst(nrst),
      .clear(csum_clear),
      .word_valid(word_valid),
      .word(word),
      .sum(csum)
   );

   function automatic logic is_auto(input logic [15:0] c, input logic npf_rsvd);
      is_auto = (c == ews_pkg::CODE_MC) || (c >= ews_pkg::CODE_INTR &&
         c <= ews_pkg::CODE_VINTR) || (c == ews_pkg::CODE_PAUSE) ||
         (c == ews_pkg::CODE_HLT) || (c == ews_pkg::CODE_SHUTDOWN) ||
         (c >= ews_pkg::CODE_FEAT_TRAP && c <= ews_pkg::CODE_CR_TRAP_LAST) ||
         (c == ews_pkg::CODE_NPF && !npf_rsvd) || (c == ews_pkg::CODE_GEXIT);
   endfunction

   function automatic logic adv_ip(input logic [15:0] c);
      adv_ip = (c == ews_pkg::CODE_PAUSE) || (c == ews_pkg::CODE_HLT) ||
         (c >= ews_pkg::CODE_FEAT_TRAP && c <= ews_pkg::CODE_CR_TRAP_LAST) ||
         (c == ews_pkg::CODE_GEXIT);
   endfunction

   function automatic ews_pkg::ews_op_t op_after(input ews_pkg::ews_op_t o);
      case (o)
         ews_pkg::OP_HOST_MIN_SAVE: op_after = ews_pkg::OP_CSUM_CHECK;
         ews_pkg::OP_CSUM_CHECK: op_after = ews_pkg::OP_XLOAD_GUEST;
         ews_pkg::OP_XLOAD_GUEST: op_after = ews_pkg::OP_LOAD_GPR;
         ews_pkg::OP_LOAD_GPR: op_after = ews_pkg::OP_LOAD_FP;
         ews_pkg::OP_XSAVE_GUEST: op_after = ews_pkg::OP_SAVE_GPR;
         ews_pkg::OP_SAVE_GPR: op_after = ews_pkg::OP_SAVE_FP;
         ews_pkg::OP_SAVE_FP: op_after = ews_pkg::OP_STORE_CSUM;
         ews_pkg::OP_STORE_CSUM: op_after = ews_pkg::OP_XLOAD_HOST;
         ews_pkg::OP_XLOAD_HOST: op_after = ews_pkg::OP_LOAD_HOST_GPR;
         ews_pkg::OP_LOAD_HOST_GPR: op_after = ews_pkg::OP_RESET_FP;
         default: op_after = ews_pkg::OP_NONE;
      endcase
   endfunction

   function automatic logic guest_op(input ews_pkg::ews_op_t o);
      guest_op = (o == ews_pkg::OP_CSUM_CHECK) || (o == ews_pkg::OP_LOAD_GPR) ||
         (o == ews_pkg::OP_LOAD_FP) || (o == ews_pkg::OP_SAVE_GPR) ||
         (o == ews_pkg::OP_SAVE_FP) || (o == ews_pkg::OP_STORE_CSUM) ||
         (o == ews_pkg::OP_XLOAD_GUEST) || (o == ews_pkg::OP_XSAVE_GUEST);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   assign bad_inj = entry.inj_valid && ((entry.inj_type == ews_pkg::INJ_TYPE_SWINT) ||
      (entry.inj_type == ews_pkg::INJ_TYPE_EXC && (entry.inj_vec == ews_pkg::VEC_BREAK ||
      entry.inj_vec == ews_pkg::VEC_OVERFLOW)));

   always_comb
   begin
      next_s = s;
      next_s.exc.valid = 1'b0;
      next_s.exit_rpt.valid = 1'b0;
      next_s.step.valid = 1'b0;
      next_s.msr_rsp = '0;
      next_s.commit.valid = 1'b0;
      next_s.hcall = 1'b0;
      next_s.smi_service = 1'b0;
      csum_clear = 1'b0;
      do_exit = 1'b0;
      ex_code = '0;
      ex_info = '0;
      ex_adv = 1'b0;
      trap_hit = 1'b0;
      wr_val = crw.value;
      if (s.enc && crw.feat)
      begin
         wr_val[ews_pkg::VIRT_ENABLE_BIT] = virt_enable_now;
      end
      if (msr_req.valid && msr_req.addr == ews_pkg::COMM_PAGE_MSR)
      begin
         next_s.msr_rsp.valid = 1'b1;
         if (!msr_req.guest_mode)
         begin
            next_s.msr_rsp.gp_fault = 1'b1;
         end
         else if (msr_req.write)
         begin
            next_s.comm_page = msr_req.wdata;
         end
         else
         begin
            next_s.msr_rsp.rdata = s.comm_page;
         end
      end
      if (s.st == ews_pkg::ST_HOST && gis_insn && s.held)
      begin
         next_s.smi_service = 1'b1;
         next_s.held = 1'b0;
      end
      if (smi_in && s.running && s.enc)
      begin
         next_s.held = 1'b1;
         next_s.held_mc = smi_mc;
      end
      case (s.st)
         ews_pkg::ST_HOST:
         begin
            if (entry.valid)
            begin
               next_s.comm_page = entry.comm_page;
               next_s.enc = entry.enc_mode;
               next_s.save_ptr = entry.save_ptr + ews_pkg::SAVE_AREA_OFS;
               next_s.reload = entry.enc_mode;
               next_s.clean = entry.enc_mode ? (entry.clean & ~ews_pkg::CLEAN_IGN_MASK) :
                  entry.clean;
               if (entry.enc_mode && bad_inj)
               begin
                  next_s.exit_rpt = {1'b1, ews_pkg::CODE_INVALID, 64'h0, 1'b0,
                     entry.comm_page};
               end
               else if (entry.enc_mode)
               begin
                  next_s.st = ews_pkg::ST_ENTRY;
                  next_s.op = ews_pkg::OP_HOST_MIN_SAVE;
                  next_s.busy = 1'b0;
                  csum_clear = 1'b1;
               end
               else
               begin
                  next_s.st = ews_pkg::ST_GUEST;
                  next_s.running = 1'b1;
               end
            end
         end
         ews_pkg::ST_ENTRY, ews_pkg::ST_EXIT:
         begin
            if (!s.busy)
            begin
               next_s.busy = 1'b1;
               next_s.step.valid = 1'b1;
               next_s.step.op = s.op;
               next_s.step.enc_key = guest_op(s.op);
               next_s.step.addr = guest_op(s.op) ? s.save_ptr : host_save_pa;
               next_s.step.wdata = csum;
            end
            else if (step_resp.ack)
            begin
               next_s.busy = 1'b0;
               next_s.op = op_after(s.op);
               if (s.st == ews_pkg::ST_ENTRY && (step_resp.fault ||
                  (s.op == ews_pkg::OP_CSUM_CHECK && step_resp.data != csum)))
               begin
                  next_s.st = ews_pkg::ST_HOST;
                  next_s.exit_rpt = {1'b1, ews_pkg::CODE_INVALID, 64'h0, 1'b0, s.comm_page};
               end
               else if (op_after(s.op) == ews_pkg::OP_NONE && s.st == ews_pkg::ST_ENTRY)
               begin
                  next_s.st = ews_pkg::ST_GUEST;
                  next_s.running = 1'b1;
               end
               else if (op_after(s.op) == ews_pkg::OP_NONE)
               begin
                  next_s.st = ews_pkg::ST_HOST;
                  next_s.exit_rpt = {1'b1, s.code, s.info1, s.adv, s.comm_page};
               end
               else if (s.op == ews_pkg::OP_SAVE_FP)
               begin
                  csum_clear = 1'b0;
               end
            end
         end
         ews_pkg::ST_GUEST:
         begin
            if (s.enc && (smi_in || s.held))
            begin
               do_exit = 1'b1;
               ex_code = ews_pkg::CODE_SMI;
               ex_info[ews_pkg::MC_REDIRECT_BIT] = smi_in ? smi_mc : s.held_mc;
            end
            else if (gexit_insn && s.enc)
            begin
               do_exit = 1'b1;
               ex_code = ews_pkg::CODE_GEXIT;
               ex_adv = 1'b1;
            end
            else if (gexit_insn)
            begin
               next_s.hcall = 1'b1;
            end
            else if (crw.valid)
            begin
               next_s.commit = {1'b1, crw.feat, crw.idx, wr_val};
               trap_hit = s.enc && (crw.feat ? feat_trap_en : cr_trap_en[crw.idx]);
               if (trap_hit)
               begin
                  do_exit = 1'b1;
                  ex_code = crw.feat ? ews_pkg::CODE_FEAT_TRAP :
                     ews_pkg::CODE_CR_TRAP + {12'h000, crw.idx};
                  ex_info = wr_val;
                  ex_adv = 1'b1;
               end
            end
            else if (evt.valid && evt.intercept)
            begin
               if (s.enc && !is_auto(evt.code, evt.npf_rsvd))
               begin
                  next_s.exc = {1'b1, ews_pkg::COMM_EXC_VECTOR, evt.code, 3'b111};
               end
               else
               begin
                  do_exit = 1'b1;
                  ex_code = evt.code;
                  ex_adv = s.enc && adv_ip(evt.code);
               end
            end
         end
         default:
         begin
            next_s.st = ews_pkg::ST_HOST;
         end
      endcase
      if (do_exit)
      begin
         next_s.running = 1'b0;
         if (ex_code == ews_pkg::CODE_SMI)
         begin
            next_s.held = 1'b1;
         end
         if (s.enc)
         begin
            next_s.st = ews_pkg::ST_EXIT;
            next_s.op = ews_pkg::OP_XSAVE_GUEST;
            next_s.busy = 1'b0;
            next_s.code = ex_code;
            next_s.info1 = ex_info;
            next_s.adv = ex_adv;
            csum_clear = 1'b1;
         end
         else
         begin
            next_s.st = ews_pkg::ST_HOST;
            next_s.exit_rpt = {1'b1, ex_code, ex_info, ex_adv, s.comm_page};
         end
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s <= '0;
         s.st <= ews_pkg::ST_HOST;
         s.op <= ews_pkg::OP_NONE;
         s.comm_page <= ews_pkg::COMM_PAGE_RESET;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign exc = s.exc;
   assign exit_rpt = s.exit_rpt;
   assign step = s.step;
   assign msr_rsp = s.msr_rsp;
   assign commit = s.commit;
   assign hcall = s.hcall;
   assign smi_service = s.smi_service;
   assign smi_held = s.held;
   assign guest_running = s.running;
   assign full_reload = s.reload;
   assign clean_eff = s.clean;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence s_enc_guest_gexit;
      s.st == ews_pkg::ST_GUEST && s.enc && gexit_insn && !smi_in && !s.held;
   endsequence
   sequence s_save_walk_start;
      s.st == ews_pkg::ST_EXIT && s.op == ews_pkg::OP_XSAVE_GUEST && s.code == ews_pkg::CODE_GEXIT
         ##1 step.valid && step.op == ews_pkg::OP_XSAVE_GUEST;
   endsequence

   a_exc_vector_class: assert property (exc.valid |-> exc.vector == 8'h1D && exc.precise &&
      exc.contributory && exc.fault) else $error("bad exception class");
   a_nae_raises_exc: assert property (s.st == ews_pkg::ST_GUEST && s.enc && !smi_in && !s.held
      && !gexit_insn && !crw.valid && evt.valid && evt.intercept && !is_auto(evt.code,
      evt.npf_rsvd) |=> exc.valid && exc.error_code == $past(evt.code))
      else $error("missing exception");
   a_gexit_auto_exit: assert property (s_enc_guest_gexit |=> s_save_walk_start)
      else $error("guest exit did not start save");
   a_gexit_plain_call: assert property (s.st == ews_pkg::ST_GUEST && !s.enc && gexit_insn
      |=> hcall && !exit_rpt.valid) else $error("opcode not hypervisor call");
   a_msr_host_fault: assert property (msr_req.valid && msr_req.addr == 32'hC0010130 &&
      !msr_req.guest_mode |=> msr_rsp.valid && msr_rsp.gp_fault && $stable(s.comm_page))
      else $error("host access not faulted");
   a_inject_refused: assert property (s.st == ews_pkg::ST_HOST && entry.valid &&
      entry.enc_mode && bad_inj |=> exit_rpt.valid && exit_rpt.code == 16'hFFFF &&
      !guest_running) else $error("bad injection accepted");
   a_save_key_used: assert property (step.valid && guest_op(step.op) |-> step.enc_key &&
      step.addr == s.save_ptr) else $error("save area step without key");
   a_clean_ignored: assert property (full_reload |-> clean_eff[10:5] == 6'h00)
      else $error("clean bits honoured");
   a_smi_redirect: assert property (s.st == ews_pkg::ST_GUEST && s.enc && smi_in && smi_mc
      |=> s.st == ews_pkg::ST_EXIT && s.code == 16'h0062 && s.info1[0] && smi_held)
      else $error("redirect bit missing");
endmodule // ews_switch

// file: sim/tb.sv
// Self-checking bench for the encrypted guest world switch, driven at its ports.
// Assumes the hand-over timing; each step answer also feeds its data as a checksum word.
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
   $display("mismatch %0t got %h want %h", $time, a, b); end end
`define WAITF(e) begin for (int k = 0; k < 40; k++) begin @(negedge clk); \
   if ((e) === 1'b1) break; end `CHK(e, 1'b1) end
module tb;
   localparam logic [63:0] PG_M = 64'h0000_0000_0003_4000;
   localparam logic [63:0] PG_E = 64'h0000_0000_0005_6000;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic gexit_insn = 1'b0;
   logic smi_in = 1'b0;
   logic smi_mc = 1'b0;
   logic gis_insn = 1'b0;
   logic word_valid = 1'b0;
   logic [63:0] word = 64'h0;
   logic feat_trap_en = 1'b0;
   logic virt_enable_now = 1'b0;
   logic [15:0] cr_trap_en = 16'h0000;
   ews_pkg::ews_entry_t entry = '0;
   ews_pkg::ews_evt_t evt = '0;
   ews_pkg::ews_crw_t crw = '0;
   ews_pkg::ews_msr_req_t msr_req = '0;
   ews_pkg::ews_resp_t step_resp = '0;
   ews_pkg::ews_exc_t exc;
   ews_pkg::ews_exit_t exit_rpt;
   ews_pkg::ews_step_t step;
   ews_pkg::ews_msr_rsp_t msr_rsp;
   ews_pkg::ews_crw_t commit;
   logic hcall, smi_service, smi_held, guest_running, full_reload;
   logic [31:0] clean_eff;
   logic [63:0] v, cv;
   int n_mismatch = 0;
   int n_compared = 0;
   int cyc = 0;

   ews_switch uut (.clk, .nrst, .entry, .host_save_pa(64'h0000_0000_0009_0000), .evt,
      .gexit_insn, .crw, .cr_trap_en, .feat_trap_en, .virt_enable_now, .smi_in, .smi_mc,
      .gis_insn, .msr_req, .step_resp, .word_valid, .word, .exc, .exit_rpt,
      .step, .msr_rsp, .commit, .hcall, .smi_service, .smi_held, .guest_running,
      .full_reload, .clean_eff);

   always #4 clk = ~clk;
   always @(negedge clk)
      if (commit.valid === 1'b1)
         cv <= commit.value;
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 4000)
      begin
         n_mismatch++;
         stop_test();
      end
   end

   ////////////////////////////////////////
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic msr(input logic wr, input logic gm, input logic [63:0] d);
      @(posedge clk);
      msr_req <= '{1'b1, wr, ews_pkg::COMM_PAGE_MSR, d, gm};
      @(posedge clk);
      msr_req.valid <= 1'b0;
      `WAITF(msr_rsp.valid)
   endtask

   task automatic enter(input logic enc, input logic iv, input logic [2:0] it,
      input logic [7:0] vec);
      @(posedge clk);
      entry <= '{1'b1, enc, 32'hFFFF_FFFF, 64'h0000_0000_0008_0000, PG_E, iv, it, vec};
      @(posedge clk);
      entry.valid <= 1'b0;
   endtask

   task automatic do_step(input int op, input logic flt, input logic [63:0] d);
      `WAITF(step.valid)
      `CHK(step.op, ews_pkg::ews_op_t'(op[3:0]))
      `CHK(step.enc_key, op >= 2 && op <= 9)
      `CHK(step.addr, (op >= 2 && op <= 9) ? 64'h8_0000 : 64'h9_0000)
      // Rotate-xor of the save words 6, 7 and 8
      if (op == 9)
         `CHK(step.wdata, 64'h1E)
      @(posedge clk);
      step_resp <= '{1'b1, flt, d};
      word_valid <= 1'b1;
      word <= d;
      @(posedge clk);
      step_resp.ack <= 1'b0;
      word_valid <= 1'b0;
   endtask

   task automatic steps(input int lo, input int hi);
      for (int i = lo; i <= hi; i++)
         do_step(i, 1'b0, 64'(i));
   endtask

   task automatic go_enc();
      enter(1'b1, 1'b0, 3'h0, 8'h00);
      do_step(1, 1'b0, 64'h0000_0000_0000_00A5);
      do_step(2, 1'b0, 64'h0000_0000_0000_00A5);
      steps(3, 5);
      `WAITF(guest_running)
      `CHK(full_reload, 1'b1)
      `CHK(clean_eff, 32'hFFFF_F81F)
   endtask

   ////////////////////////////////////////
   initial
   begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      msr(1'b0, 1'b0, 64'h0);
      `CHK(msr_rsp.gp_fault, 1'b1)
      msr(1'b1, 1'b1, PG_M);
      msr(1'b1, 1'b0, 64'h0000_0000_0000_7000);
      msr(1'b0, 1'b1, 64'h0);
      `CHK(msr_rsp.rdata, PG_M)
      $display("msr done");
      for (int i = 0; i < 3; i++)
      begin
         enter(1'b1, 1'b1, i < 2 ? ews_pkg::INJ_TYPE_EXC : ews_pkg::INJ_TYPE_SWINT, 8'h03 + i[7:0]);
         `WAITF(exit_rpt.valid)
         `CHK(exit_rpt.code, ews_pkg::CODE_INVALID)
      end
      for (int j = 0; j < 2; j++)
      begin
         enter(1'b1, 1'b0, 3'h0, 8'h00);
         do_step(1, j == 0, 64'h0);
         if (j == 1)
            do_step(2, 1'b0, 64'h1);
         `WAITF(exit_rpt.valid)
         `CHK(exit_rpt.code, ews_pkg::CODE_INVALID)
      end
      $display("entry abort done");
      go_enc();
      msr(1'b0, 1'b1, 64'h0);
      `CHK(msr_rsp.rdata, PG_E)
      msr(1'b1, 1'b1, PG_M);
      @(posedge clk);
      evt <= '{1'b1, 16'h007B, 1'b1, 1'b0};
      @(posedge clk);
      evt.valid <= 1'b0;
      `WAITF(exc.valid)
      `CHK(exc, ews_pkg::ews_exc_t'{1'b1, 8'h1D, 16'h007B, 1'b1, 1'b1, 1'b1})
      @(posedge clk);
      gexit_insn <= 1'b1;
      @(posedge clk);
      gexit_insn <= 1'b0;
      steps(6, 12);
      `WAITF(exit_rpt.valid)
      `CHK(exit_rpt.code, ews_pkg::CODE_GEXIT)
      `CHK(exit_rpt.adv_ip, 1'b1)
      `CHK(exit_rpt.comm_page, PG_M)
      $display("exception and guest exit done");
      @(posedge clk);
      cr_trap_en <= 16'h0008;
      feat_trap_en <= 1'b1;
      for (int j = 0; j < 2; j++)
      begin
         go_enc();
         v = (j == 0) ? 64'h0000_0000_0000_0D01 : 64'h0000_0000_0000_1D01;
         @(posedge clk);
         crw <= '{1'b1, j == 0, 4'h3, 64'h0000_0000_0000_1D01};
         @(posedge clk);
         crw.valid <= 1'b0;
         steps(6, 12);
         `WAITF(exit_rpt.valid)
         `CHK(cv, v)
         `CHK(exit_rpt.code, (j == 0) ? ews_pkg::CODE_FEAT_TRAP : 16'h0093)
         `CHK(exit_rpt.info1, v)
      end
      $display("write trap done");
      go_enc();
      @(posedge clk);
      smi_in <= 1'b1;
      smi_mc <= 1'b1;
      @(posedge clk);
      smi_in <= 1'b0;
      steps(6, 12);
      `WAITF(exit_rpt.valid)
      `CHK(exit_rpt.code, ews_pkg::CODE_SMI)
      `CHK(exit_rpt.info1[0], 1'b1)
      `CHK(exit_rpt.adv_ip, 1'b0)
      `CHK(smi_held, 1'b1)
      @(posedge clk);
      gis_insn <= 1'b1;
      @(posedge clk);
      gis_insn <= 1'b0;
      `WAITF(smi_service)
      @(negedge clk);
      `CHK(smi_held, 1'b0)
      $display("held interrupt done");
      enter(1'b0, 1'b0, 3'h0, 8'h00);
      `WAITF(guest_running)
      @(posedge clk);
      gexit_insn <= 1'b1;
      @(posedge clk);
      gexit_insn <= 1'b0;
      `WAITF(hcall)
      $display("plain guest done");
      stop_test();
   end
endmodule // tb
